// ### design/vrlc_pkg.sv
// Shared constants and types of the voltage reference ladder control block.
package vrlc_pkg;

   localparam int VRLC_ADDR_W = 4;
   localparam int VRLC_DATA_W = 32;
   localparam int VRLC_TAPS = 16;
   localparam int VRLC_LEVEL_W = 7;

   // Byte offsets on the register bus.
   localparam logic [VRLC_ADDR_W-1:0] VRLC_OFF_SHARED = 4'h0;
   localparam logic [VRLC_ADDR_W-1:0] VRLC_OFF_WATCHDOG = 4'h4;
   localparam logic [VRLC_ADDR_W-1:0] VRLC_OFF_STATUS = 4'h8;

   // Values after reset.
   localparam logic [7:0] VRLC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] VRLC_TIMER_PERIOD_RESET = 8'h00;
   localparam logic VRLC_ALT_SELECT_RESET = 1'b0;

   // Field positions inside the control register.
   localparam int VRLC_POWER_BIT = 7;
   localparam int VRLC_PIN_BIT = 6;
   localparam int VRLC_RANGE_BIT = 5;
   localparam int VRLC_SOURCE_BIT = 4;
   localparam int VRLC_CODE_MSB = 3;
   localparam int VRLC_CODE_LSB = 0;

   // Field position inside the watchdog control register.
   localparam int VRLC_ALT_SEL_BIT = 4;

   // Ladder level expressed in ninety-sixths of the supply span.
   localparam logic [VRLC_LEVEL_W-1:0] VRLC_LEVEL_DEN = 7'h60;
   localparam logic [VRLC_LEVEL_W-1:0] VRLC_LOW_STEP = 7'h04;
   localparam logic [VRLC_LEVEL_W-1:0] VRLC_HIGH_STEP = 7'h03;
   localparam logic [VRLC_LEVEL_W-1:0] VRLC_HIGH_BASE = 7'h18;

   // Bus slave states.
   typedef enum logic {
      VRLC_BUS_IDLE = 1'b0,
      VRLC_BUS_ACK = 1'b1
   } vrlc_bus_t;

endpackage

// ### design/vrlc_ladder_decode.sv
// Decoder from the control register to the analog ladder control lines.
`timescale 1ns/100ps
module vrlc_ladder_decode
   import vrlc_pkg::*;
#(
   parameter int TAPS = VRLC_TAPS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] control,
   input wire logic port_f_direction_in,
   output logic ladder_power_on,
   output logic ladder_pin_output_on,
   output logic ladder_range_select,
   output logic ladder_source_select,
   output logic [TAPS-1:0] ladder_tap_select,
   output logic [VRLC_LEVEL_W-1:0] ladder_level,
   output logic port_f5_direction
);

   localparam int CODE_W = $clog2(TAPS);

   logic [CODE_W-1:0] code;
   logic [VRLC_LEVEL_W-1:0] next_level;

   assign code = control[VRLC_CODE_LSB +: CODE_W];

   always_comb begin
      if (control[VRLC_RANGE_BIT]) begin
         next_level = VRLC_LEVEL_W'(code) * VRLC_LOW_STEP;
      end else begin
         next_level = VRLC_HIGH_BASE + VRLC_LEVEL_W'(code) * VRLC_HIGH_STEP;
      end
   end

   // Settings act on the ladder alone; the comparators never gate them.
   always_ff @(posedge clock) begin
      if (reset) begin
         ladder_power_on <= 1'b0;
         ladder_pin_output_on <= 1'b0;
         ladder_range_select <= 1'b0;
         ladder_source_select <= 1'b0;
         ladder_level <= '0;
         port_f5_direction <= 1'b1;
      end else begin
         ladder_power_on <= control[VRLC_POWER_BIT];
         ladder_pin_output_on <= control[VRLC_PIN_BIT];
         ladder_range_select <= control[VRLC_RANGE_BIT];
         ladder_source_select <= control[VRLC_SOURCE_BIT];
         ladder_level <= next_level;
         // The pin is released as an input so the port driver cannot fight the level.
         port_f5_direction <= control[VRLC_PIN_BIT] | port_f_direction_in;
      end
   end

   // A powered-down ladder opens every tap so no path draws current.
   for (genvar i = 0; i < TAPS; i++) begin : g_tap
      always_ff @(posedge clock) begin
         if (reset) begin
            ladder_tap_select[i] <= 1'b0;
         end else begin
            ladder_tap_select[i] <= control[VRLC_POWER_BIT] && (code == CODE_W'(i));
         end
      end
   end

endmodule

// ### design/vrlc_control_bank.sv
// Voltage reference ladder control register bank with its Avalon-MM slave.
`timescale 1ns/100ps
// Notes on behaviour
// - Top control bit set powers the ladder; clear powers it down.
// - Bit six routes the level to the pin, overriding that pin's direction.
// - Bit five picks low range in 24ths from zero or high range in 32nds.
// - Bit four picks external reference pins when set, analog rails when clear.
// - Low four bits hold a tap code 0 to 15, sixteen levels.
// - Shared address reaches the control register only while alternate select is set.
// - Reset clears the register: ladder off, pin disconnected, high range.
// - Waking from sleep leaves every control bit unchanged.
// - Ladder settings act independently of the comparator module.
module vrlc_control_bank
   import vrlc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [VRLC_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [VRLC_DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [VRLC_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic port_f_direction_in,
   output logic port_f5_direction,
   output logic ladder_power_on,
   output logic ladder_pin_output_on,
   output logic ladder_range_select,
   output logic ladder_source_select,
   output logic [VRLC_TAPS-1:0] ladder_tap_select,
   output logic [VRLC_LEVEL_W-1:0] ladder_output_level,
   output logic [7:0] timer_period_reg,
   output logic alternate_register_select
);

   vrlc_bus_t state;
   logic [7:0] voltage_reference_control;
   logic hit_control;
   logic hit_timer;
   logic hit_watchdog;
   logic hit_status;
   logic request;
   logic access_taken;
   logic write_taken;
   logic [VRLC_DATA_W-1:0] next_readdata;
   logic [7:0] status_view;

   assign request = avs_read || avs_write;

   // One shared offset serves two registers, steered by the alternate select.
   assign hit_control = (avs_address == VRLC_OFF_SHARED) && alternate_register_select;
   assign hit_timer = (avs_address == VRLC_OFF_SHARED) && !alternate_register_select;
   assign hit_watchdog = (avs_address == VRLC_OFF_WATCHDOG);
   assign hit_status = (avs_address == VRLC_OFF_STATUS);

   // Data are taken at the edge where waitrequest is seen low.
   assign access_taken = (state == VRLC_BUS_ACK) && request;
   assign write_taken = access_taken && avs_write && avs_byteenable[0];

   assign status_view = {ladder_power_on, ladder_output_level};

   always_comb begin
      next_readdata = '0;
      if (hit_control) begin
         next_readdata[7:0] = voltage_reference_control;
      end else if (hit_timer) begin
         next_readdata[7:0] = timer_period_reg;
      end else if (hit_watchdog) begin
         next_readdata[VRLC_ALT_SEL_BIT] = alternate_register_select;
      end else if (hit_status) begin
         next_readdata[7:0] = status_view;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state <= VRLC_BUS_IDLE;
      end else begin
         unique case (state)
            VRLC_BUS_IDLE: begin
               if (request) begin
                  state <= VRLC_BUS_ACK;
               end
            end
            VRLC_BUS_ACK: begin
               state <= VRLC_BUS_IDLE;
            end
         endcase
      end
   end

   // Waitrequest stays high in reset and idle so no request slips through unseen.
   always_ff @(posedge clock) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if (state == VRLC_BUS_IDLE) begin
         avs_waitrequest <= !request;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Read data are captured one cycle early; no write can land in between.
   always_ff @(posedge clock) begin
      if (reset) begin
         avs_readdata <= '0;
      end else if ((state == VRLC_BUS_IDLE) && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end

   // Only a device reset clears the register; sleep and wake have no path here.
   always_ff @(posedge clock) begin
      if (reset) begin
         voltage_reference_control <= VRLC_CONTROL_RESET;
      end else if (write_taken && hit_control) begin
         voltage_reference_control <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         timer_period_reg <= VRLC_TIMER_PERIOD_RESET;
      end else if (write_taken && hit_timer) begin
         timer_period_reg <= avs_writedata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         alternate_register_select <= VRLC_ALT_SELECT_RESET;
      end else if (write_taken && hit_watchdog) begin
         alternate_register_select <= avs_writedata[VRLC_ALT_SEL_BIT];
      end
   end

   // Powering down before sleep is left to software; the bank never forces it.
   vrlc_ladder_decode #(
      .TAPS(VRLC_TAPS)
   ) u_decode (
      .clock(clock),
      .reset(reset),
      .control(voltage_reference_control),
      .port_f_direction_in(port_f_direction_in),
      .ladder_power_on(ladder_power_on),
      .ladder_pin_output_on(ladder_pin_output_on),
      .ladder_range_select(ladder_range_select),
      .ladder_source_select(ladder_source_select),
      .ladder_tap_select(ladder_tap_select),
      .ladder_level(ladder_output_level),
      .port_f5_direction(port_f5_direction)
   );

   power_follow_a: assert property (
      @(posedge clock) disable iff (reset)
      !$past(reset) |->
         ladder_power_on == $past(voltage_reference_control[VRLC_POWER_BIT])
   ) else $error("Ladder power does not follow the enable bit.");

   pin_route_a: assert property (
      @(posedge clock) disable iff (reset)
      (!$past(reset) && $past(voltage_reference_control[VRLC_PIN_BIT])) |->
         (ladder_pin_output_on && port_f5_direction)
   ) else $error("Pin output does not override the port direction.");

   pin_release_a: assert property (
      @(posedge clock) disable iff (reset)
      (!$past(reset) && !$past(voltage_reference_control[VRLC_PIN_BIT])) |->
         (!ladder_pin_output_on && port_f5_direction == $past(port_f_direction_in))
   ) else $error("Pin direction not restored when output is off.");

   level_low_a: assert property (
      @(posedge clock) disable iff (reset)
      (!$past(reset) && $past(voltage_reference_control[VRLC_RANGE_BIT])) |->
         (ladder_range_select &&
          ladder_output_level ==
             VRLC_LEVEL_W'($past(voltage_reference_control[3:0])) * VRLC_LOW_STEP)
   ) else $error("Low range level is wrong.");

   level_high_a: assert property (
      @(posedge clock) disable iff (reset)
      (!$past(reset) && !$past(voltage_reference_control[VRLC_RANGE_BIT])) |->
         (!ladder_range_select &&
          ladder_output_level == VRLC_HIGH_BASE +
             VRLC_LEVEL_W'($past(voltage_reference_control[3:0])) * VRLC_HIGH_STEP)
   ) else $error("High range level is wrong.");

   source_sel_a: assert property (
      @(posedge clock) disable iff (reset)
      !$past(reset) |->
         ladder_source_select == $past(voltage_reference_control[VRLC_SOURCE_BIT])
   ) else $error("Source select does not follow its bit.");

   tap_onehot_a: assert property (
      @(posedge clock) disable iff (reset)
      !$past(reset) |->
         (ladder_tap_select ==
            ($past(voltage_reference_control[VRLC_POWER_BIT]) ?
               (VRLC_TAPS'(1) << $past(voltage_reference_control[3:0])) : '0))
   ) else $error("Tap select is not the coded one-hot tap.");

   shared_timer_a: assert property (
      @(posedge clock) disable iff (reset)
      (write_taken && hit_timer) |=>
         ($stable(voltage_reference_control) &&
          timer_period_reg == $past(avs_writedata[7:0]))
   ) else $error("Timer access leaked into the control register.");

   reset_clear_a: assert property (
      @(posedge clock)
      reset |=>
         (voltage_reference_control == VRLC_CONTROL_RESET && !alternate_register_select)
   ) else $error("Reset did not clear the control register.");

   reset_outputs_a: assert property (
      @(posedge clock) disable iff (reset)
      $past(reset) |->
         (!ladder_power_on && !ladder_pin_output_on && !ladder_range_select &&
          ladder_tap_select == '0)
   ) else $error("Ladder not off after reset.");

   sleep_hold_a: assert property (
      @(posedge clock) disable iff (reset)
      !(write_taken && hit_control) |=> $stable(voltage_reference_control)
   ) else $error("Control register changed without a write.");

   write_store_a: assert property (
      @(posedge clock) disable iff (reset)
      (write_taken && hit_control) |=>
         voltage_reference_control == $past(avs_writedata[7:0])
   ) else $error("Written control value not stored.");

   read_back_a: assert property (
      @(posedge clock) disable iff (reset)
      (state == VRLC_BUS_IDLE && avs_read && hit_control) |=>
         (avs_readdata == {24'h000000, voltage_reference_control} && !avs_waitrequest)
   ) else $error("Control read does not return the stored value.");

   wait_bound_a: assert property (
      @(posedge clock) disable iff (reset)
      (request && avs_waitrequest) |-> ##[1:2] !avs_waitrequest
   ) else $error("Waitrequest held too long.");

   wait_single_a: assert property (
      @(posedge clock) disable iff (reset)
      !avs_waitrequest |=> avs_waitrequest
   ) else $error("Waitrequest low for more than one cycle.");

   status_ro_a: assert property (
      @(posedge clock) disable iff (reset)
      (write_taken && hit_status) |=>
         ($stable(voltage_reference_control) && $stable(timer_period_reg) &&
          $stable(alternate_register_select))
   ) else $error("A write to the status view changed a register.");

   byte_lane_a: assert property (
      @(posedge clock) disable iff (reset)
      (access_taken && avs_write && !avs_byteenable[0]) |=>
         ($stable(voltage_reference_control) && $stable(timer_period_reg))
   ) else $error("A write without byte lane zero changed a register.");

   control_only_a: assert property (
      @(posedge clock) disable iff (reset)
      (write_taken && hit_control) |=> $stable(timer_period_reg)
   ) else $error("Control access leaked into the timer period register.");

   timer_read_a: assert property (
      @(posedge clock) disable iff (reset)
      (state == VRLC_BUS_IDLE && avs_read && hit_timer) |=>
         avs_readdata == {24'h000000, timer_period_reg}
   ) else $error("Timer read does not return the stored period.");

   taps_dark_a: assert property (
      @(posedge clock) disable iff (reset)
      !ladder_power_on |-> ladder_tap_select == '0
   ) else $error("A tap is selected while the ladder is powered down.");

   pin_input_a: assert property (
      @(posedge clock) disable iff (reset)
      ladder_pin_output_on |-> port_f5_direction
   ) else $error("Pin is not released as an input while the level is routed.");

   high_floor_a: assert property (
      @(posedge clock) disable iff (reset)
      (ladder_power_on && !ladder_range_select) |-> ladder_output_level >= VRLC_HIGH_BASE
   ) else $error("High range level lies below its base.");

   wait_reset_a: assert property (
      @(posedge clock)
      reset |=> (avs_waitrequest && avs_readdata == '0)
   ) else $error("Bus outputs not idle after reset.");

endmodule

// ### verif/vref_ladder_control_register_tb_top.sv
// Self-checking testbench of the voltage reference ladder control register bank.
`timescale 1ns/100ps
module vref_ladder_control_register_tb_top
   import vrlc_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [VRLC_ADDR_W-1:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [VRLC_DATA_W-1:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [VRLC_DATA_W-1:0] avs_readdata;
   logic avs_waitrequest;
   logic port_f_direction_in = 1'b1;
   logic port_f5_direction;
   logic ladder_power_on;
   logic ladder_pin_output_on;
   logic ladder_range_select;
   logic ladder_source_select;
   logic [VRLC_TAPS-1:0] ladder_tap_select;
   logic [VRLC_LEVEL_W-1:0] ladder_output_level;
   logic [7:0] timer_period_reg;
   logic alternate_register_select;
   int err_total = 0;
   int cmp_count = 0;
   logic [7:0] tbl [5] = '{8'h8f, 8'ha7, 8'hd0, 8'h30, 8'hff};

   vrlc_control_bank dut (.clock(clock), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .port_f_direction_in(port_f_direction_in),
      .port_f5_direction(port_f5_direction), .ladder_power_on(ladder_power_on),
      .ladder_pin_output_on(ladder_pin_output_on), .ladder_range_select(ladder_range_select),
      .ladder_source_select(ladder_source_select), .ladder_tap_select(ladder_tap_select),
      .ladder_output_level(ladder_output_level), .timer_period_reg(timer_period_reg),
      .alternate_register_select(alternate_register_select));

   always #5 clock = ~clock;

   task report_and_stop;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Waitrequest is sampled with its value from before the edge, so the edge
   // at which it reads low is the one where the transfer completes.
   task bus_access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                   input logic [3:0] be, output logic [7:0] q);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      // Only the watchdog ends a wait that never sees waitrequest low.
      do begin
         @(posedge clock);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      if (!wr) chk("readdata_upper", 32'h0, {avs_readdata[31:8], 8'h00});
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask

   task bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      logic [7:0] unused;
      bus_access(1'b1, a, d, be, unused);
   endtask

   task bus_read_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus_access(1'b0, a, 8'h00, 4'hf, q);
      chk(what, {24'h0, exp}, {24'h0, q});
   endtask

   function automatic logic [27:0] ladder_exp(input logic [7:0] c, input logic d);
      logic [15:0] taps;
      logic [6:0] lvl;
      taps = c[7] ? (16'h0001 << c[3:0]) : 16'h0000;
      lvl = c[5] ? {1'b0, c[3:0], 2'b00} : 7'h18 + 7'(c[3:0]) * 7'h03;
      return {c[7:4], taps, lvl, c[6] | d};
   endfunction

   // Outputs are looked at on the falling edge, after the decoder has caught up.
   task chk_ladder(input logic [7:0] c);
      @(negedge clock);
      chk("ladder", {4'h0, ladder_exp(c, port_f_direction_in)},
          {4'h0, ladder_power_on, ladder_pin_output_on, ladder_range_select,
           ladder_source_select, ladder_tap_select, ladder_output_level, port_f5_direction});
      @(posedge clock);
   endtask

   initial begin
      #50000;
      err_total++;
      report_and_stop;
   end

   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk_ladder(8'h00);
      bus_read_chk("timer_reset", VRLC_OFF_SHARED, 8'h00);
      bus_read_chk("watchdog_reset", VRLC_OFF_WATCHDOG, 8'h00);
      bus_write(VRLC_OFF_SHARED, 8'ha5, 4'hf);
      bus_read_chk("timer_rw", VRLC_OFF_SHARED, 8'ha5);
      chk_ladder(8'h00);
      bus_write(VRLC_OFF_WATCHDOG, 8'hff, 4'hf);
      bus_read_chk("alt_select", VRLC_OFF_WATCHDOG, 8'h10);
      bus_read_chk("control_reset", VRLC_OFF_SHARED, 8'h00);
      foreach (tbl[i]) begin
         bus_write(VRLC_OFF_SHARED, tbl[i], 4'hf);
         chk_ladder(tbl[i]);
         bus_read_chk("control_rw", VRLC_OFF_SHARED, tbl[i]);
      end
      // Direction override must win over a port that asks for output.
      port_f_direction_in <= 1'b0;
      bus_write(VRLC_OFF_SHARED, 8'h40, 4'hf);
      chk_ladder(8'h40);
      bus_write(VRLC_OFF_SHARED, 8'h00, 4'hf);
      chk_ladder(8'h00);
      bus_write(VRLC_OFF_SHARED, 8'ha7, 4'hf);
      bus_read_chk("status", VRLC_OFF_STATUS, 8'h9c);
      bus_write(VRLC_OFF_STATUS, 8'h00, 4'hf);
      bus_write(VRLC_OFF_SHARED, 8'h55, 4'he);
      bus_write(4'hc, 8'h77, 4'hf);
      bus_read_chk("unmapped", 4'hc, 8'h00);
      bus_read_chk("control_kept", VRLC_OFF_SHARED, 8'ha7);
      // Software powers the ladder down before the idle stretch that stands for sleep.
      bus_write(VRLC_OFF_SHARED, 8'h27, 4'hf);
      repeat (20) @(posedge clock);
      bus_read_chk("control_hold", VRLC_OFF_SHARED, 8'h27);
      chk_ladder(8'h27);
      bus_write(VRLC_OFF_WATCHDOG, 8'h00, 4'hf);
      bus_read_chk("timer_kept", VRLC_OFF_SHARED, 8'ha5);
      chk("timer_port", 32'ha5, {24'h0, timer_period_reg});
      bus_write(VRLC_OFF_WATCHDOG, 8'h10, 4'hf);
      bus_write(VRLC_OFF_SHARED, 8'hff, 4'hf);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk_ladder(8'h00);
      chk("alt_port", 32'h0, {31'h0, alternate_register_select});
      bus_write(VRLC_OFF_WATCHDOG, 8'h10, 4'hf);
      bus_read_chk("control_cleared", VRLC_OFF_SHARED, 8'h00);
      report_and_stop;
   end
endmodule
